// ===== bench/sbc_checker_assertions.sv
// Purpose: assertions on the controller-device link and bank states
// Assumes: controller and device share the watched link
// Notes: bank state {bank1, bank0}, one-hot 7 bits each
`timescale 1ns/1ps
module sbc_checker_assertions (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [sbc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [13:0] bank_state_i,
  input wire logic illegal_i,
  input wire logic done_i
);
  // ==========================================================
  // state codes of one bank
  localparam logic [6:0] S_IDLE = sbc_pkg::SBC_IDLE;
  localparam logic [6:0] S_OPENING = sbc_pkg::SBC_ROW_TO_COLUMN;
  localparam logic [6:0] S_ACTIVE = sbc_pkg::SBC_ROW_ACTIVE;
  localparam logic [6:0] S_WRITE_AP = sbc_pkg::SBC_WRITE_AUTOPRECHARGE;
  localparam logic [6:0] S_RECOVER = sbc_pkg::SBC_WRITE_RECOVERY;
  localparam logic [6:0] S_PRECHARGE = sbc_pkg::SBC_ROW_PRECHARGE;
  // ==========================================================
  // command decode and bank fields
  logic [3:0] cmd;
  logic [6:0] b0;
  logic [6:0] b1;
  logic quiet;
  logic bank;
  logic is_act;
  assign cmd = cs_n_i ? 4'h8 : {1'b0, ras_n_i, cas_n_i, we_n_i};
  assign bank = addr_i[sbc_pkg::BANK_SELECT_BIT];
  assign is_act = (cmd == sbc_pkg::SBC_ROW_ACTIVATE_CMD);
  assign b0 = bank_state_i[6:0];
  assign b1 = bank_state_i[13:7];
  assign quiet = (cmd == sbc_pkg::SBC_DESELECT_CMD) || (cmd == sbc_pkg::SBC_NOP_CMD) ||
                 (cmd == sbc_pkg::SBC_BURST_STOP_CMD);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================================
  // assertions
  a_no_illegal_cmd: assert property (!illegal_i)
    else $error("illegal command flagged on controller link");
  a_act_opens_row: assert property (is_act && !bank && b0 == S_IDLE |=> b0 == S_OPENING)
    else $error("activate did not open bank0 row");
  a_rcd_elapses: assert property (b0 == S_OPENING && quiet |=> b0 == S_ACTIVE)
    else $error("row-to-column delay not one cycle");
  a_burst_length: assert property (
    $rose(b0 == S_WRITE_AP) |-> (b0 == S_WRITE_AP)[*4] ##1 b0 == S_RECOVER)
    else $error("autoprecharge burst length wrong");
  a_recover_precharge: assert property (
    $fell(b0 == S_WRITE_AP) |-> b0 == S_RECOVER ##1 b0 == S_PRECHARGE)
    else $error("recovery not followed by precharge");
  a_precharge_idles: assert property (b0 == S_PRECHARGE && quiet |=> b0 == S_IDLE)
    else $error("precharge did not end in idle");
  a_bank_isolated: assert property (!bank && b1 == S_IDLE |=> b1 == S_IDLE)
    else $error("bank1 moved on a bank0 command");
  a_state_onehot: assert property ($onehot(b0) && $onehot(b1))
    else $error("bank state not one-hot");
  a_done_pulse: assert property (done_i |=> !done_i)
    else $error("done held longer than one cycle");
  // main scenarios seen
  c_done: cover property ($rose(done_i));
  c_wap0: cover property ($rose(b0 == S_WRITE_AP));
  c_row1: cover property ($rose(b1 == S_OPENING));
  c_rec0: cover property ($rose(b0 == S_RECOVER));
endmodule

// ===== bench/tb.sv
// Purpose: testbench for controller and device, plus a directly driven device
// Assumes: 50 MHz clock, inputs changed at falling edge
// Notes: second link breaks rules on purpose
`timescale 1ns/1ps
module tb;
  logic sys_clk_i;
  logic nrst_i;
  logic req_i;
  logic bank_i;
  logic [10:0] row_i;
  logic busy_o;
  logic done_o;
  logic [13:0] st_a;
  logic [13:0] st_b;
  logic il_a;
  logic rd_b;
  logic wr_b;
  logic il_b;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int acts = 0;
  sbc_cmd_if bus_a ();
  sbc_cmd_if bus_b ();
  sbc_controller sbc_controller_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req_i),
    .bank_i(bank_i), .row_i(row_i), .busy_o(busy_o), .done_o(done_o), .pins(bus_a));
  sbc_device sbc_device_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .pins(bus_a),
    .bank_state_o(st_a), .read_start_o(), .write_start_o(), .illegal_o(il_a));
  sbc_device sbc_device_b_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .pins(bus_b),
    .bank_state_o(st_b), .read_start_o(rd_b), .write_start_o(wr_b), .illegal_o(il_b));
  sbc_checker_assertions sbc_checker_assertions_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .cs_n_i(bus_a.cs_n), .ras_n_i(bus_a.ras_n), .cas_n_i(bus_a.cas_n),
    .we_n_i(bus_a.we_n), .addr_i(bus_a.addr), .bank_state_i(st_a),
    .illegal_i(il_a), .done_i(done_o));
  // ==========================================================
  // clock, timeout, activate counter
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (nrst_i && !bus_a.cs_n && {bus_a.ras_n, bus_a.cas_n, bus_a.we_n} == 3'b011) acts++;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one command on the second link, outcome visible on return
  task automatic issue(input logic [3:0] c, input logic [11:0] a);
    {bus_b.cs_n, bus_b.ras_n, bus_b.cas_n, bus_b.we_n} = c;
    bus_b.addr = a;
    @(negedge sys_clk_i);
  endtask
  // nops until the bank shows the wanted state
  task automatic reach(input logic bk, input logic [6:0] s);
    int n;
    n = 0;
    while ((bk ? st_b[13:7] : st_b[6:0]) !== s && n < 20) begin
      issue(4'h7, 12'h000);
      n++;
    end
    chk(bk ? st_b[13:7] : st_b[6:0], s);
  endtask
  // one user request, a refused one while busy, wait for done
  task automatic request(input logic bk, input logic [10:0] r);
    int n;
    int w;
    int o;
    int b;
    int e;
    n = 0;
    w = 0;
    o = 0;
    b = 0;
    // busy spans activate, row-to-column gap, write, burst, recovery, precharge
    e = 2 + sbc_pkg::ROW_TO_COLUMN_DELAY_CYC + sbc_pkg::BURST_LEN +
        sbc_pkg::DATA_IN_TO_PRECHARGE_CYC + sbc_pkg::ROW_PRECHARGE_CYC;
    bank_i = bk;
    row_i = r;
    req_i = 1'b1;
    while (done_o !== 1'b1 && n < 60) begin
      @(negedge sys_clk_i);
      req_i = (n == 4);
      w += ((bk ? st_a[13:7] : st_a[6:0]) == 7'h10);
      o += ((bk ? st_a[6:0] : st_a[13:7]) != 7'h01);
      b += (busy_o === 1'b1);
      n++;
    end
    chk(14'(w), 14'(sbc_pkg::BURST_LEN));
    chk(14'(o), 14'h0000);
    chk(14'(b), 14'(e));
    chk({13'h0000, done_o}, 14'h0001);
    @(negedge sys_clk_i);
    chk(st_a, 14'h0081);
  endtask
  task automatic finish_test();
    $display("mismatches %0d, comparisons %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    nrst_i = 1'b0;
    req_i = 1'b0;
    bank_i = 1'b0;
    row_i = 11'h000;
    {bus_b.cs_n, bus_b.ras_n, bus_b.cas_n, bus_b.we_n} = 4'h7;
    bus_b.addr = 12'h000;
    repeat (6) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    request(1'b0, 11'h7ff);
    request(1'b1, 11'h000);
    chk(14'(acts), 14'h0002);
    issue(4'h3, 12'h000);
    chk({7'h00, st_b[6:0]}, 14'h0002);
    issue(4'h5, 12'h000);
    chk({il_b, st_b[6:0]}, 14'h0084);
    chk({13'h0000, rd_b}, 14'h0000);
    issue(4'h4, 12'h000);
    reach(1'b0, 7'h20);
    issue(4'h5, 12'h000);
    chk({il_b, rd_b}, 14'h0001);
    reach(1'b0, 7'h04);
    issue(4'h4, 12'h000);
    reach(1'b0, 7'h20);
    issue(4'h4, 12'h000);
    chk({il_b, wr_b}, 14'h0001);
    reach(1'b0, 7'h20);
    issue(4'h6, 12'h000);
    chk({il_b, st_b[6:0]}, 14'h0004);
    issue(4'h4, 12'h000);
    reach(1'b0, 7'h20);
    issue(4'h3, 12'h000);
    chk({13'h0000, il_b}, 14'h0001);
    reach(1'b0, 7'h04);
    issue(4'h4, 12'h400);
    issue(4'h6, 12'h000);
    chk({il_b, st_b[6:0]}, 14'h0090);
    issue(4'h3, 12'h800);
    chk({il_b, st_b[13:7]}, 14'h0002);
    issue(4'h1, 12'h000);
    chk({13'h0000, il_b}, 14'h0001);
    issue(4'h0, 12'h000);
    chk({13'h0000, il_b}, 14'h0001);
    reach(1'b0, 7'h40);
    issue(4'h3, 12'h000);
    chk({il_b, st_b[6:0]}, 14'h0081);
    reach(1'b1, 7'h04);
    issue(4'h2, 12'h800);
    issue(4'h2, 12'h800);
    chk({il_b, st_b[13:7]}, 14'h0001);
    // second bank opened one bank-to-bank delay after the first
    issue(4'h3, 12'h000);
    issue(4'h3, 12'h800);
    chk({il_b, st_b[13:7]}, 14'h0002);
    chk({il_b, st_b[6:0]}, 14'h0004);
    finish_test();
  end
endmodule

// ===== hdl/sbc_cmd_if.sv
// Purpose: command pins between controller and two-bank device
// Assumes: one clock, commands sampled on rising edge
// Notes: all pins are one-way, controller to device
`timescale 1ns/1ps
interface sbc_cmd_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [sbc_pkg::ADDR_W-1:0] addr;
  modport ctrl (output cs_n, output ras_n, output cas_n, output we_n, output addr);
  modport dev (input cs_n, input ras_n, input cas_n, input we_n, input addr);
endinterface

// ===== hdl/sbc_controller.sv
// Purpose: controller end driving legal command sequences to the device
// Assumes: user request held until accepted
// Notes: one request: activate, write autoprecharge, wait to idle
`timescale 1ns/1ps
module sbc_controller #(
  parameter int BURST = sbc_pkg::BURST_LEN
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic bank_i,
  input wire logic [10:0] row_i,
  output logic busy_o,
  output logic done_o,
  sbc_cmd_if.ctrl pins
);
  typedef enum logic [4:0] {
    C_IDLE = 5'h01, C_ACT = 5'h02, C_WAIT_RCD = 5'h04, C_WRITE = 5'h08, C_WAIT_END = 5'h10
  } sbc_ctl_state_t;

  typedef struct packed {
    sbc_ctl_state_t st;
    logic [sbc_pkg::CNT_W-1:0] cnt;
    logic [3:0] cmd;
    logic [sbc_pkg::ADDR_W-1:0] addr;
    logic busy;
    logic done;
  } sbc_ctl_t;

  sbc_ctl_t cur;
  sbc_ctl_t next_cur;

  // ==========================================================
  // sequencer, waits every bank timing before the next command
  always_comb begin
    next_cur = cur;
    next_cur.cmd = sbc_pkg::SBC_NOP_CMD;
    next_cur.done = 1'b0;
    if (cur.cnt != '0) begin
      next_cur.cnt = cur.cnt - 1'b1;
    end
    unique case (cur.st)
      C_IDLE: begin
        if (req_i) begin
          next_cur.st = C_ACT;
          next_cur.busy = 1'b1;
          next_cur.addr = {bank_i, row_i};
          next_cur.cmd = sbc_pkg::SBC_ROW_ACTIVATE_CMD;
          // full count: the bank leaves row-to-column one edge after its own count
          next_cur.cnt = sbc_pkg::CNT_W'(sbc_pkg::ROW_TO_COLUMN_DELAY_CYC);
        end
      end
      // RULE6 no column command before delay
      C_ACT, C_WAIT_RCD: begin
        next_cur.st = C_WAIT_RCD;
        if (cur.cnt == '0) begin
          next_cur.st = C_WRITE;
          next_cur.cmd = sbc_pkg::SBC_WRITE_CMD;
          next_cur.addr[sbc_pkg::AUTO_PRECHARGE_BIT] = 1'b1;
          next_cur.cnt = sbc_pkg::CNT_W'(BURST + sbc_pkg::DATA_IN_TO_PRECHARGE_CYC
                          + sbc_pkg::ROW_PRECHARGE_CYC);
        end
      end
      // RULE2 RULE4 only nops until idle
      C_WRITE, C_WAIT_END: begin
        next_cur.st = C_WAIT_END;
        if (cur.cnt == '0) begin
          next_cur.st = C_IDLE;
          next_cur.busy = 1'b0;
          next_cur.done = 1'b1;
        end
      end
      default: begin
        next_cur.st = C_IDLE;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur <= '{st: C_IDLE, cmd: sbc_pkg::SBC_NOP_CMD, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // RULE11 drive strobe levels
  assign pins.cs_n = cur.cmd[3];
  assign pins.ras_n = cur.cmd[2];
  assign pins.cas_n = cur.cmd[1];
  assign pins.we_n = cur.cmd[0];
  assign pins.addr = cur.addr;
  assign busy_o = cur.busy;
  assign done_o = cur.done;
endmodule

// ===== hdl/sbc_device.sv
// What this block does
// RULE1 - write autoprecharge finishes, recovers, then precharges
// RULE2 - controller avoids illegal commands during write autoprecharge
// RULE3 - precharging bank ignores nop commands, idles after tRP
// RULE4 - precharging bank takes no read, write, activate
// RULE5 - after activate, nops wait row-to-column delay
// RULE6 - no read, write, precharge before delay ends
// RULE7 - write recovery returns row-active after recovery time
// RULE8 - read during recovery starts new read burst
// RULE9 - write during recovery restarts write burst
// RULE10 - recovery ignores burst stop; no activate, precharge
// RULE11 - command decoded from select and strobe levels
// RULE12 - separate state per bank, chosen by bank bit
// RULE13 - bank-dependent commands checked against selected bank
// RULE14 - second activate waits bank-to-bank delay; the device does not check it, BANK_TO_BANK_ACTIVATE_CYC is unused
// RULE15 - all inputs sampled on rising clock edge
//
// Purpose: per-bank command state tracking of the memory device
// Assumes: pins come from logic on the same clock
// Notes: illegal_o pulses on any command forbidden in the bank's state
`timescale 1ns/1ps
module sbc_device #(
  parameter int BURST = sbc_pkg::BURST_LEN
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  sbc_cmd_if.dev pins,
  output logic [13:0] bank_state_o,
  output logic read_start_o,
  output logic write_start_o,
  output logic illegal_o
);
  // ==========================================================
  // state of both banks and the registered outputs
  typedef struct packed {
    sbc_pkg::sbc_bank_state_t [1:0] st;
    logic [1:0][sbc_pkg::CNT_W-1:0] cnt;
    logic [1:0] ap;
    logic [13:0] state_out;
    logic rd;
    logic wr;
    logic bad;
  } sbc_dev_t;

  sbc_dev_t cur;
  sbc_dev_t next_cur;
  // decoded command of this edge and the bank it names
  sbc_pkg::sbc_cmd_t cmd;
  logic bank;
  logic ap_bit;

  // ==========================================================
  // command decode
  // RULE11 decode strobe levels
  always_comb begin
    if (pins.cs_n) begin
      cmd = sbc_pkg::SBC_DESELECT_CMD;
    end else begin
      cmd = sbc_pkg::sbc_cmd_t'({1'b0, pins.ras_n, pins.cas_n, pins.we_n});
    end
  end
  // RULE12 bank select bit
  assign bank = pins.addr[sbc_pkg::BANK_SELECT_BIT];
  // auto-precharge request rides on the address
  assign ap_bit = pins.addr[sbc_pkg::AUTO_PRECHARGE_BIT];

  // ==========================================================
  // next state of both banks
  // timed states stand for n edges after their command, so a command on
  // one of those edges is judged against the waiting state, not the next one
  always_comb begin
    next_cur = cur;
    next_cur.rd = 1'b0;
    next_cur.wr = 1'b0;
    next_cur.bad = 1'b0;
    // RULE15 one decision per edge
    for (int b = 0; b < 2; b++) begin
      if (cur.cnt[b] != '0) begin
        next_cur.cnt[b] = cur.cnt[b] - 1'b1;
      end
      unique case (cur.st[b])
        // idle bank opens a row on activate
        sbc_pkg::SBC_IDLE: begin
          if (cmd == sbc_pkg::SBC_ROW_ACTIVATE_CMD && bank == b[0]) begin
            next_cur.st[b] = sbc_pkg::SBC_ROW_TO_COLUMN;
            next_cur.cnt[b] = sbc_pkg::CNT_W'(sbc_pkg::ROW_TO_COLUMN_DELAY_CYC - 1);
          end
        end
        // RULE5 wait row-to-column
        sbc_pkg::SBC_ROW_TO_COLUMN: begin
          if (cur.cnt[b] == '0) begin
            next_cur.st[b] = sbc_pkg::SBC_ROW_ACTIVE;
          end
        end
        // open row starts bursts or precharges
        sbc_pkg::SBC_ROW_ACTIVE: begin
          if (bank == b[0] && cmd == sbc_pkg::SBC_WRITE_CMD) begin
            next_cur.st[b] = ap_bit ? sbc_pkg::SBC_WRITE_AUTOPRECHARGE
                                    : sbc_pkg::SBC_WRITE_BURST;
            next_cur.cnt[b] = sbc_pkg::CNT_W'(BURST - 1);
            next_cur.wr = 1'b1;
          end else if (bank == b[0] && cmd == sbc_pkg::SBC_READ_CMD) begin
            next_cur.rd = 1'b1;
          end else if (bank == b[0] && cmd == sbc_pkg::SBC_PRECHARGE_CMD) begin
            next_cur.st[b] = sbc_pkg::SBC_ROW_PRECHARGE;
            next_cur.cnt[b] = sbc_pkg::CNT_W'(sbc_pkg::ROW_PRECHARGE_CYC - 1);
          end
        end
        // plain write burst ends in recovery
        sbc_pkg::SBC_WRITE_BURST: begin
          if (cur.cnt[b] == '0) begin
            next_cur.st[b] = sbc_pkg::SBC_WRITE_RECOVERY;
            next_cur.ap[b] = 1'b0;
            next_cur.cnt[b] = sbc_pkg::CNT_W'(sbc_pkg::DATA_IN_TO_PRECHARGE_CYC - 1);
          end
        end
        // RULE1 finish, recover, precharge
        sbc_pkg::SBC_WRITE_AUTOPRECHARGE: begin
          if (cur.cnt[b] == '0) begin
            next_cur.st[b] = sbc_pkg::SBC_WRITE_RECOVERY;
            next_cur.ap[b] = 1'b1;
            next_cur.cnt[b] = sbc_pkg::CNT_W'(sbc_pkg::DATA_IN_TO_PRECHARGE_CYC - 1);
          end
        end
        // write recovery restarts a burst or waits out its time
        sbc_pkg::SBC_WRITE_RECOVERY: begin
          // RULE8 read restarts burst
          if (bank == b[0] && cmd == sbc_pkg::SBC_READ_CMD && !cur.ap[b]) begin
            next_cur.st[b] = sbc_pkg::SBC_ROW_ACTIVE;
            next_cur.rd = 1'b1;
          // RULE9 write restarts burst
          end else if (bank == b[0] && cmd == sbc_pkg::SBC_WRITE_CMD && !cur.ap[b]) begin
            next_cur.st[b] = ap_bit ? sbc_pkg::SBC_WRITE_AUTOPRECHARGE
                                    : sbc_pkg::SBC_WRITE_BURST;
            next_cur.cnt[b] = sbc_pkg::CNT_W'(BURST - 1);
            next_cur.wr = 1'b1;
          // RULE7 recovery time done
          end else if (cur.cnt[b] == '0) begin
            if (cur.ap[b]) begin
              next_cur.st[b] = sbc_pkg::SBC_ROW_PRECHARGE;
              next_cur.cnt[b] = sbc_pkg::CNT_W'(sbc_pkg::ROW_PRECHARGE_CYC - 1);
            end else begin
              next_cur.st[b] = sbc_pkg::SBC_ROW_ACTIVE;
            end
          end
        end
        // RULE3 idle after precharge
        sbc_pkg::SBC_ROW_PRECHARGE: begin
          if (cur.cnt[b] == '0) begin
            next_cur.st[b] = sbc_pkg::SBC_IDLE;
          end
        end
        // broken one-hot code falls back to idle
        default: begin
          next_cur.st[b] = sbc_pkg::SBC_IDLE;
        end
      endcase
    end
    // RULE13 legality against selected bank
    unique case (cmd)
      sbc_pkg::SBC_REFRESH_CMD, sbc_pkg::SBC_MODE_REGISTER_SET_CMD: begin
        next_cur.bad = (cur.st[0] != sbc_pkg::SBC_IDLE) ||
                       (cur.st[1] != sbc_pkg::SBC_IDLE);
      end
      sbc_pkg::SBC_BURST_STOP_CMD: begin
        // RULE10 burst stop ignored in recovery
        next_cur.bad = (cur.st[0] == sbc_pkg::SBC_WRITE_AUTOPRECHARGE) ||
                       (cur.st[1] == sbc_pkg::SBC_WRITE_AUTOPRECHARGE);
      end
      sbc_pkg::SBC_READ_CMD, sbc_pkg::SBC_WRITE_CMD: begin
        next_cur.bad = !(cur.st[bank] inside {sbc_pkg::SBC_ROW_ACTIVE,
                         sbc_pkg::SBC_WRITE_BURST}) &&
                       !(cur.st[bank] == sbc_pkg::SBC_WRITE_RECOVERY && !cur.ap[bank]);
      end
      sbc_pkg::SBC_ROW_ACTIVATE_CMD: begin
        next_cur.bad = cur.st[bank] != sbc_pkg::SBC_IDLE;
      end
      sbc_pkg::SBC_PRECHARGE_CMD: begin
        next_cur.bad = !(cur.st[bank] inside {sbc_pkg::SBC_IDLE, sbc_pkg::SBC_ROW_ACTIVE,
                         sbc_pkg::SBC_ROW_PRECHARGE, sbc_pkg::SBC_WRITE_BURST});
      end
      default: begin
        next_cur.bad = 1'b0;
      end
    endcase
    next_cur.state_out = {next_cur.st[1], next_cur.st[0]};
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // reset leaves both banks idle, pulses low
      cur <= '{st: '{sbc_pkg::SBC_IDLE, sbc_pkg::SBC_IDLE},
               state_out: {sbc_pkg::SBC_IDLE, sbc_pkg::SBC_IDLE}, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================
  // outputs, each straight from the state register
  assign bank_state_o = cur.state_out;
  assign read_start_o = cur.rd;
  assign write_start_o = cur.wr;
  assign illegal_o = cur.bad;
endmodule

// ===== hdl/sbc_pkg.sv
// Purpose: shared constants and types for the two-bank command state logic
// Assumes: 50 MHz system clock, one rising-edge domain
// Notes: timing figures in ns, cycle counts derived from them
package sbc_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int ROW_PRECHARGE_NS = 20;
  localparam int ROW_TO_COLUMN_DELAY_NS = 20;
  localparam int DATA_IN_TO_PRECHARGE_NS = 20;
  localparam int BANK_TO_BANK_ACTIVATE_NS = 20;
  localparam int BURST_LEN = 4;
  // least times round up, never below one cycle
  localparam int ROW_PRECHARGE_CYC =
    (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_TO_COLUMN_DELAY_CYC =
    (ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_IN_TO_PRECHARGE_CYC =
    (DATA_IN_TO_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BANK_TO_BANK_ACTIVATE_CYC =
    (BANK_TO_BANK_ACTIVATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam int ADDR_W = 12;
  localparam int BANK_SELECT_BIT = 11;
  localparam int AUTO_PRECHARGE_BIT = 10;

  // ==========================================================
  // commands as {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SBC_DESELECT_CMD = 4'h8,
    SBC_NOP_CMD = 4'h7,
    SBC_BURST_STOP_CMD = 4'h6,
    SBC_READ_CMD = 4'h5,
    SBC_WRITE_CMD = 4'h4,
    SBC_ROW_ACTIVATE_CMD = 4'h3,
    SBC_PRECHARGE_CMD = 4'h2,
    SBC_REFRESH_CMD = 4'h1,
    SBC_MODE_REGISTER_SET_CMD = 4'h0
  } sbc_cmd_t;

  // bank states, one-hot
  typedef enum logic [6:0] {
    SBC_IDLE = 7'h01,
    SBC_ROW_TO_COLUMN = 7'h02,
    SBC_ROW_ACTIVE = 7'h04,
    SBC_WRITE_BURST = 7'h08,
    SBC_WRITE_AUTOPRECHARGE = 7'h10,
    SBC_WRITE_RECOVERY = 7'h20,
    SBC_ROW_PRECHARGE = 7'h40
  } sbc_bank_state_t;
endpackage
